// ==== logic/ami_pkg.sv ====
// constants and types for the asynchronous memory interface
// Function
// - read_write_sel high reads, low writes
// - output enable low in read strobe
// - write enable low in write strobe
// - four active-low chip selects, one per space
// - normal mode: select spans whole cycle
// - select-strobe mode: select only during strobe
// - address from word address plus bank bits
// - lowest address bit is word LSB
// - bank bits carry halfword or byte LSBs
// - 8 or 16 bit width per space
// - asserted wait lengthens strobe when enabled
// - per-input wait polarity
// - setup from address valid to strobe
// - strobe from strobe assert to deassert
// - hold from strobe end to cycle end
// - separate read and write timings
// - durations counted in interface clocks
// - NAND mode ECC over 512 bytes, on 8 bit spaces only
// - select-strobe bit: 0 normal, 1 strobe
// - timing fields hold cycles minus one
// - turnaround gap, skipped for RR, same-space WW
package ami_pkg;
  localparam int SPACES       = 4;
  localparam int ADDR_W       = 25;
  localparam int EXT_ADDR_W   = 23;
  localparam int DATA_W       = 16;
  localparam int SETUP_W      = 4;
  localparam int STROBE_W     = 6;
  localparam int HOLD_W       = 3;
  localparam int TA_W         = 2;
  localparam int CNT_W        = 6;
  localparam int GAP_W        = 3;
  localparam int ECC_IDX_W    = 9;
  localparam int ECC_W        = 24;
  localparam logic [ECC_IDX_W-1:0] ECC_LAST_BYTE = 9'h1ff;
  localparam logic [SPACES-1:0]    CS_IDLE_N     = 4'hf;

  typedef enum logic [2:0] {
    AMI_IDLE,
    AMI_TURN,
    AMI_SETUP,
    AMI_STROBE,
    AMI_HOLD
  } ami_state_t;
endpackage

// ==== logic/ami_async_memory_interface.sv ====
// asynchronous external memory cycle engine with NAND ECC accumulator
`timescale 1ns/10ps
module ami_async_memory_interface (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // request side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_space,
  input  wire logic [24:0] req_addr,
  input  wire logic [15:0] req_wdata,
  // read return
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  // per-space configuration, one field per space
  input  wire logic [3:0]  select_strobe,
  input  wire logic [3:0]  extended_wait_enable,
  input  wire logic [3:0]  wide_bus,
  input  wire logic [3:0]  nand_mode,
  input  wire logic [15:0] r_setup,
  input  wire logic [23:0] r_strobe,
  input  wire logic [11:0] r_hold,
  input  wire logic [15:0] w_setup,
  input  wire logic [23:0] w_strobe,
  input  wire logic [11:0] w_hold,
  input  wire logic [7:0]  turnaround_min,
  input  wire logic [3:0]  wait_polarity,
  input  wire logic [3:0]  wait_in,
  // NAND ECC accumulator
  input  wire logic        ecc_clear,
  output logic             ecc_done,
  output logic [23:0]      ecc_value,
  // memory pins
  output logic [22:0]      ext_addr_out,
  output logic [1:0]       bank_addr_out,
  output logic [3:0]       chip_sel_n,
  output logic             read_write_sel,
  output logic             output_enable_n,
  output logic             write_enable_n,
  input  wire logic [15:0] ext_data_bus_in,
  output logic [15:0]      ext_data_bus_out,
  output logic             ext_data_bus_oe
);

  typedef struct packed {
    ami_pkg::ami_state_t            state;
    logic [ami_pkg::CNT_W-1:0]      cnt;
    logic [1:0]                     space;
    logic                           write;
    logic [ami_pkg::ADDR_W-1:0]     addr;
    logic [ami_pkg::DATA_W-1:0]     wdata;
    logic [ami_pkg::DATA_W-1:0]     rdata;
    logic                           rd_valid;
    logic                           last_valid;
    logic                           last_write;
    logic [1:0]                     last_space;
    logic [ami_pkg::GAP_W-1:0]      gap;
    logic [ami_pkg::SPACES-1:0]     cs_n;
    logic                           oe_n;
    logic                           we_n;
    logic                           rw;
    logic                           data_oe;
    logic [ami_pkg::ECC_IDX_W-1:0]  ecc_idx;
    logic [ami_pkg::ECC_IDX_W-1:0]  ecc_odd;
    logic [ami_pkg::ECC_IDX_W-1:0]  ecc_even;
    logic [5:0]                     ecc_col;
    logic [ami_pkg::ECC_W-1:0]      ecc_value;
    logic                           ecc_done;
  } ami_regs_t;

  // idle pins: selects and strobes high, rw parked at read
  localparam ami_regs_t RESET_REGS = '{
    state:      ami_pkg::AMI_IDLE,
    cnt:        '0,
    space:      '0,
    write:      1'b0,
    addr:       '0,
    wdata:      '0,
    rdata:      '0,
    rd_valid:   1'b0,
    last_valid: 1'b0,
    last_write: 1'b0,
    last_space: '0,
    gap:        '0,
    cs_n:       ami_pkg::CS_IDLE_N,
    oe_n:       1'b1,
    we_n:       1'b1,
    rw:         1'b1,
    data_oe:    1'b0,
    ecc_idx:    '0,
    ecc_odd:    '0,
    ecc_even:   '0,
    ecc_col:    '0,
    ecc_value:  '0,
    ecc_done:   1'b0
  };

  ami_regs_t state_reg;
  ami_regs_t state_next;

  logic [ami_pkg::SETUP_W-1:0]  setup_sel;
  logic [ami_pkg::STROBE_W-1:0] strobe_sel;
  logic [ami_pkg::HOLD_W-1:0]   hold_sel;
  logic [ami_pkg::TA_W-1:0]     ta_sel;
  logic [ami_pkg::GAP_W-1:0]    gap_left;
  logic                         need_gap;
  logic                         wait_asserted;
  logic                         ecc_take;
  logic [7:0]                   ecc_byte;
  logic [1:0]                   sp;
  logic                         wr;

  // per-space views of the flattened configuration buses
  logic [ami_pkg::SETUP_W-1:0]  r_setup_sp  [ami_pkg::SPACES];
  logic [ami_pkg::SETUP_W-1:0]  w_setup_sp  [ami_pkg::SPACES];
  logic [ami_pkg::STROBE_W-1:0] r_strobe_sp [ami_pkg::SPACES];
  logic [ami_pkg::STROBE_W-1:0] w_strobe_sp [ami_pkg::SPACES];
  logic [ami_pkg::HOLD_W-1:0]   r_hold_sp   [ami_pkg::SPACES];
  logic [ami_pkg::HOLD_W-1:0]   w_hold_sp   [ami_pkg::SPACES];
  logic [ami_pkg::TA_W-1:0]     ta_sp       [ami_pkg::SPACES];
  logic [ami_pkg::SPACES-1:0]   wait_sp;

  // one slice set per chip-select space
  for (genvar g = 0; g < ami_pkg::SPACES; g++) begin : g_space
    assign r_setup_sp[g]  = r_setup[g*ami_pkg::SETUP_W +:
                                    ami_pkg::SETUP_W];
    assign w_setup_sp[g]  = w_setup[g*ami_pkg::SETUP_W +:
                                    ami_pkg::SETUP_W];
    assign r_strobe_sp[g] = r_strobe[g*ami_pkg::STROBE_W +:
                                     ami_pkg::STROBE_W];
    assign w_strobe_sp[g] = w_strobe[g*ami_pkg::STROBE_W +:
                                     ami_pkg::STROBE_W];
    assign r_hold_sp[g]   = r_hold[g*ami_pkg::HOLD_W +:
                                   ami_pkg::HOLD_W];
    assign w_hold_sp[g]   = w_hold[g*ami_pkg::HOLD_W +:
                                   ami_pkg::HOLD_W];
    assign ta_sp[g]       = turnaround_min[g*ami_pkg::TA_W +:
                                           ami_pkg::TA_W];

    // polarity: 1 means high is asserted
    assign wait_sp[g] = extended_wait_enable[g] &&
                        (wait_in[g] == wait_polarity[g]);
  end

  always_comb begin
    state_next    = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.ecc_done = 1'b0;
    ecc_take      = 1'b0;
    ecc_byte      = 8'h00;
    need_gap      = 1'b0;
    sp            = state_reg.space;
    wr            = state_reg.write;
    if (state_reg.state == ami_pkg::AMI_IDLE) begin
      sp = req_space;
      wr = req_write;
    end
    setup_sel     = wr ? w_setup_sp[sp]  : r_setup_sp[sp];
    strobe_sel    = wr ? w_strobe_sp[sp] : r_strobe_sp[sp];
    hold_sel      = wr ? w_hold_sp[sp]   : r_hold_sp[sp];
    ta_sel        = ta_sp[sp];
    wait_asserted = wait_sp[sp];
    gap_left = (state_reg.gap == '0) ? '0 : state_reg.gap - 3'h1;

    unique case (state_reg.state)
      ami_pkg::AMI_IDLE: begin
        state_next.gap = gap_left;
        if (req_valid) begin
          state_next.space = req_space;
          state_next.write = req_write;
          state_next.addr  = req_addr;
          state_next.wdata = req_write ? req_wdata : state_reg.wdata;
          // gap skipped for RR and same-space WW
          need_gap = state_reg.last_valid &&
                     !((!state_reg.last_write && !req_write) ||
                       (state_reg.last_write && req_write &&
                        state_reg.last_space == req_space));
          // counters load field, i.e. cycles minus one
          if (!need_gap || state_reg.gap <= 3'h1) begin
            state_next.state = ami_pkg::AMI_SETUP;
            state_next.cnt   = ami_pkg::CNT_W'(setup_sel);
            state_next.gap   = '0;
          end else begin
            state_next.state = ami_pkg::AMI_TURN;
          end
        end
      end
      ami_pkg::AMI_TURN: begin
        state_next.gap = gap_left;
        if (state_reg.gap <= 3'h1) begin
          state_next.state = ami_pkg::AMI_SETUP;
          state_next.cnt   = ami_pkg::CNT_W'(setup_sel);
          state_next.gap   = '0;
        end
      end
      ami_pkg::AMI_SETUP: begin
        if (state_reg.cnt == '0) begin
          state_next.state = ami_pkg::AMI_STROBE;
          state_next.cnt   = strobe_sel;
        end else begin
          state_next.cnt = state_reg.cnt - 6'h01;
        end
      end
      ami_pkg::AMI_STROBE: begin
        if (wait_asserted) begin
          state_next.cnt = state_reg.cnt;
        end else if (state_reg.cnt == '0) begin
          state_next.state = ami_pkg::AMI_HOLD;
          state_next.cnt   = ami_pkg::CNT_W'(hold_sel);
          if (!state_reg.write) begin
            state_next.rd_valid = 1'b1;
            // narrow spaces read low byte only
            state_next.rdata = wide_bus[sp] ? ext_data_bus_in :
                               {8'h00, ext_data_bus_in[7:0]};
          end
          // low lane only, so wide spaces never feed the ECC
          ecc_take = nand_mode[sp] && !wide_bus[sp];
          ecc_byte = state_reg.write ? state_reg.wdata[7:0] :
                     ext_data_bus_in[7:0];
        end else begin
          state_next.cnt = state_reg.cnt - 6'h01;
        end
      end
      // hold, cycle ends on select release in normal mode
      ami_pkg::AMI_HOLD: begin
        if (state_reg.cnt == '0) begin
          state_next.state      = ami_pkg::AMI_IDLE;
          // gap is reckoned from the space just finished
          state_next.gap        = ami_pkg::GAP_W'(ta_sel) + 3'h1;
          state_next.last_valid = 1'b1;
          state_next.last_write = state_reg.write;
          state_next.last_space = state_reg.space;
        end else begin
          state_next.cnt = state_reg.cnt - 6'h01;
        end
      end
    endcase

    // row and column parity over 512 bytes
    if (ecc_clear) begin
      state_next.ecc_idx  = '0;
      state_next.ecc_odd  = '0;
      state_next.ecc_even = '0;
      state_next.ecc_col  = '0;
    end else if (ecc_take) begin
      for (int k = 0; k < ami_pkg::ECC_IDX_W; k++) begin
        if (state_reg.ecc_idx[k]) begin
          state_next.ecc_odd[k] = state_reg.ecc_odd[k] ^ (^ecc_byte);
        end else begin
          state_next.ecc_even[k] = state_reg.ecc_even[k] ^ (^ecc_byte);
        end
      end
      for (int c = 0; c < 3; c++) begin
        for (int b = 0; b < 8; b++) begin
          if (b[c]) begin
            state_next.ecc_col[2*c+1] = state_next.ecc_col[2*c+1]
                                        ^ ecc_byte[b];
          end else begin
            state_next.ecc_col[2*c] = state_next.ecc_col[2*c]
                                      ^ ecc_byte[b];
          end
        end
      end
      state_next.ecc_idx = state_reg.ecc_idx + 9'h001;
      if (state_reg.ecc_idx == ami_pkg::ECC_LAST_BYTE) begin
        state_next.ecc_value = {state_next.ecc_odd, state_next.ecc_even,
                                state_next.ecc_col};
        state_next.ecc_done  = 1'b1;
        state_next.ecc_idx   = '0;
        state_next.ecc_odd   = '0;
        state_next.ecc_even  = '0;
        state_next.ecc_col   = '0;
      end
    end

    // pins follow the phase being entered, so they come from flops
    state_next.cs_n    = ami_pkg::CS_IDLE_N;
    state_next.oe_n    = 1'b1;
    state_next.we_n    = 1'b1;
    state_next.rw      = 1'b1;
    state_next.data_oe = 1'b0;
    if (state_next.state == ami_pkg::AMI_SETUP ||
        state_next.state == ami_pkg::AMI_STROBE ||
        state_next.state == ami_pkg::AMI_HOLD) begin
      state_next.rw      = !state_next.write;
      state_next.data_oe = state_next.write;
      if (!select_strobe[state_next.space] ||
          state_next.state == ami_pkg::AMI_STROBE) begin
        state_next.cs_n[state_next.space] = 1'b0;
      end
      if (state_next.state == ami_pkg::AMI_STROBE) begin
        state_next.oe_n = state_next.write;
        state_next.we_n = !state_next.write;
      end
    end
  end

  // every phase counts interface clock cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= RESET_REGS;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // combinational so a waiting request is taken without a lost cycle
  assign req_ready        = (state_reg.state == ami_pkg::AMI_IDLE) && ce;
  assign rd_valid         = state_reg.rd_valid;
  assign rd_data          = state_reg.rdata;
  assign ecc_done         = state_reg.ecc_done;
  assign ecc_value        = state_reg.ecc_value;
  // lowest pin is word address LSB
  assign ext_addr_out     = state_reg.addr[24:2];
  // halfword LSB on upper bank bit, bytes on both
  assign bank_addr_out    = wide_bus[state_reg.space] ?
                            {state_reg.addr[1], 1'b0} :
                            state_reg.addr[1:0];
  assign chip_sel_n       = state_reg.cs_n;
  assign read_write_sel   = state_reg.rw;
  assign output_enable_n  = state_reg.oe_n;
  assign write_enable_n   = state_reg.we_n;
  // narrow spaces use the low byte lane only
  assign ext_data_bus_out = wide_bus[state_reg.space] ? state_reg.wdata :
                            {8'h00, state_reg.wdata[7:0]};
  assign ext_data_bus_oe  = state_reg.data_oe;

endmodule

// ==== verification/ami_async_memory_interface_chk.sv ====
// assertion checker on the memory cycle engine pins
`timescale 1ns/10ps
module ami_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        req_ready,
  input wire logic        rd_valid,
  input wire logic [22:0] ext_addr_out,
  input wire logic [3:0]  chip_sel_n,
  input wire logic        read_write_sel,
  input wire logic        output_enable_n,
  input wire logic        write_enable_n,
  input wire logic        ext_data_bus_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_read_oe: assert property (
    !output_enable_n |-> read_write_sel && write_enable_n)
    else $error("oe low outside read");
  a_write_we: assert property (
    !write_enable_n |-> !read_write_sel && ext_data_bus_oe)
    else $error("we low outside write");
  a_read_release: assert property (
    !output_enable_n |-> !ext_data_bus_oe) else $error("bus driven in read");
  a_one_select: assert property (
    $onehot0(~chip_sel_n)) else $error("several selects low");
  a_strobe_select: assert property (
    !(output_enable_n && write_enable_n) |-> chip_sel_n != 4'hf)
    else $error("strobe without select");
  a_setup_addr: assert property (
    $fell(output_enable_n) |-> $stable(ext_addr_out))
    else $error("address not set up");
  a_rdv_end: assert property (
    rd_valid |-> output_enable_n && !$past(output_enable_n))
    else $error("read data not at strobe end");
  a_idle_pins: assert property (
    req_ready |-> chip_sel_n == 4'hf && output_enable_n && write_enable_n)
    else $error("pins busy while idle");
  a_write_hold: assert property (
    $rose(write_enable_n) |-> !read_write_sel) else $error("rw left write");
  c_read: cover property (rd_valid);
  c_write: cover property ($fell(write_enable_n));
  c_ss_read: cover property (!output_enable_n && !chip_sel_n[1]);
endmodule

bind ami_async_memory_interface ami_chk u_chk (.clk, .reset, .req_ready,
  .rd_valid, .ext_addr_out, .chip_sel_n, .read_write_sel,
  .output_enable_n, .write_enable_n, .ext_data_bus_oe);

// ==== verification/ami_mem_model.sv ====
// behavioural external memory answering the cycle engine's strobes
`timescale 1ns/10ps
module ami_mem_model (
  input  wire logic        clk,
  input  wire logic [22:0] addr,
  input  wire logic [1:0]  bank,
  input  wire logic [3:0]  sel_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] din,
  input  wire logic [3:0]  pol,
  input  wire logic [3:0]  slow,
  output logic [15:0]      dout,
  output logic [3:0]       wait_o
);
  logic [15:0] mem [64];
  logic [15:0] last_reg = 16'h0;
  logic [3:0]  cnt_reg = 4'h0;
  logic        stb;
  assign stb = sel_n != 4'hf && !(oe_n && we_n);
  // wait held for the first slow strobe cycles
  assign wait_o = (stb && cnt_reg < slow) ? pol : ~pol;
  // released bus shows the inverse of its last value, so it toggles every cycle
  assign dout = (stb && !oe_n) ? mem[{addr[3:0], bank}] : ~last_reg;
  always @(posedge clk) begin
    last_reg <= dout;
    cnt_reg <= stb ? cnt_reg + 4'h1 : 4'h0;
    if (stb && !we_n)
      mem[{addr[3:0], bank}] <= din;
  end
endmodule

// ==== verification/ami_async_memory_interface_tb.sv ====
// self-checking bench for the asynchronous memory cycle engine
`timescale 1ns/10ps
module ami_async_memory_interface_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [1:0]  req_space = 2'h0;
  logic [24:0] req_addr = 25'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [3:0]  select_strobe = 4'h2;
  logic [3:0]  extended_wait_enable = 4'h4;
  logic [3:0]  wide_bus = 4'hd;
  logic [15:0] r_setup = 16'h0001;
  logic [23:0] r_strobe = 24'h041042;
  logic [11:0] r_hold = 12'h008;
  logic [15:0] w_setup = 16'h0000;
  logic [23:0] w_strobe = 24'h041041;
  logic [11:0] w_hold = 12'h249;
  logic [7:0]  turnaround_min = 8'h03;
  logic [3:0]  wait_polarity = 4'h8;
  logic [3:0]  slow = 4'h0;
  logic [3:0]  nand_mode = 4'h0;
  logic        ecc_clear = 1'b0;
  logic        ecc_done;
  logic [23:0] ecc_value;
  int          ecc_seen = 0;
  logic        req_ready, rd_valid, read_write_sel, ext_data_bus_oe;
  logic        output_enable_n, write_enable_n;
  logic [15:0] rd_data, ext_data_bus_in, ext_data_bus_out, mdrv;
  logic [22:0] ext_addr_out;
  logic [1:0]  bank_addr_out;
  logic [3:0]  chip_sel_n, wait_in;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;
  assign ext_data_bus_in = ext_data_bus_oe ? ext_data_bus_out : mdrv;

  ami_async_memory_interface uut (.clk, .reset, .ce(1'b1), .req_valid,
    .req_ready, .req_write, .req_space, .req_addr, .req_wdata, .rd_valid,
    .rd_data, .select_strobe, .extended_wait_enable, .wide_bus,
    .nand_mode, .r_setup, .r_strobe, .r_hold, .w_setup, .w_strobe,
    .w_hold, .turnaround_min, .wait_polarity, .wait_in, .ecc_clear,
    .ecc_done, .ecc_value, .ext_addr_out, .bank_addr_out, .chip_sel_n,
    .read_write_sel, .output_enable_n, .write_enable_n, .ext_data_bus_in,
    .ext_data_bus_out, .ext_data_bus_oe);
  ami_mem_model mem (.clk, .addr(ext_addr_out), .bank(bank_addr_out),
    .sel_n(chip_sel_n), .oe_n(output_enable_n), .we_n(write_enable_n),
    .din(ext_data_bus_in), .pol(wait_polarity), .slow, .dout(mdrv),
    .wait_o(wait_in));

  always @(posedge clk) begin
    if (ecc_done === 1'b1) ecc_seen++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one access; g extra gap cycles, nw wait cycles expected
  task automatic acc(input logic w, input logic [1:0] sp,
    input logic [24:0] a, input logic [15:0] d, input int g, nw);
    int k, pre, st, post, rv, s, t, h;
    s = w ? w_setup[4*sp+:4] : r_setup[4*sp+:4];
    t = w ? w_strobe[6*sp+:6] : r_strobe[6*sp+:6];
    h = w ? w_hold[3*sp+:3] : r_hold[3*sp+:3];
    pre = 0; st = 0; post = 0; rv = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_space <= sp;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    for (k = 1; k < 200; k++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) rv = k;
      if (!(output_enable_n && write_enable_n)) begin
        st++;
        chk("rw", read_write_sel, !w);
        chk("sel", chip_sel_n[sp], 1'b0);
        chk("addr", ext_addr_out, a[24:2]);
        chk("bank", bank_addr_out, wide_bus[sp] ? {a[1], 1'b0} : a[1:0]);
        chk("doe", ext_data_bus_oe, w);
        if (w) chk("wdat", ext_data_bus_out, wide_bus[sp] ? d : d[7:0]);
      end else if (chip_sel_n[sp] === 1'b0) begin
        if (st > 0) post++;
        else pre++;
      end
      if (req_ready === 1'b1) break;
    end
    chk("setup", pre, select_strobe[sp] ? 0 : s + 1);
    chk("strobe", st, t + 1 + nw);
    chk("hold", post, select_strobe[sp] ? 0 : h + 1);
    if (!w) chk("rlat", rv, 3 + g + s + t + nw);
    if (!w) chk("rdat", rd_data, d);
  endtask

  // turnaround on each direction change within the space, none between reads
  task automatic t_wide;
    acc(1, 0, 25'h0000006, 16'hc3a5, 0, 0);
    acc(0, 0, 25'h0000006, 16'hc3a5, 2, 0);
    acc(0, 0, 25'h0000006, 16'hc3a5, 0, 0);
    acc(1, 0, 25'h0000004, 16'h1234, 2, 0);
    acc(0, 0, 25'h0000004, 16'h1234, 2, 0);
  endtask

  task automatic t_narrow;
    acc(1, 1, 25'h0000013, 16'h5aa5, 0, 0);
    acc(0, 1, 25'h0000013, 16'h00a5, 0, 0);
  endtask

  // both wait polarities on the extended space
  task automatic t_wait;
    slow <= 4'h3;
    acc(1, 2, 25'h0000020, 16'h0f0f, 0, 3);
    acc(0, 2, 25'h0000020, 16'h0f0f, 0, 3);
    @(posedge clk) wait_polarity[2] <= 1'b1;
    acc(0, 2, 25'h0000020, 16'h0f0f, 0, 3);
  endtask

  // wait asserted but ignored on a space without extended wait
  task automatic t_noext;
    acc(1, 3, 25'h0000028, 16'h8001, 0, 0);
    acc(0, 3, 25'h0000028, 16'h8001, 0, 0);
  endtask

  // 512 byte writes on the narrow space, one marked byte at index 5
  task automatic t_ecc;
    int i;
    @(posedge clk);
    nand_mode <= 4'h2;
    ecc_clear <= 1'b1;
    @(posedge clk);
    ecc_clear <= 1'b0;
    for (i = 0; i < 512; i++) begin
      if (i == 511) chk("ecc_early", ecc_seen, 0);
      acc(1, 1, 25'(i), (i == 5) ? 16'h0080 : 16'h0000, 0, 0);
    end
    chk("ecc_done", ecc_seen, 1);
    chk("ecc", ecc_value, 24'h02feaa);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_wide;
    t_narrow;
    t_wait;
    t_noext;
    t_ecc;
    results;
  end

  initial begin
    repeat (10000) @(posedge clk);
    mismatches++;
    results;
  end
endmodule
